// ### src/ext_bus_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the external bus configuration block.
 * Assumes a 16-bit register port addressed by the printed offsets.
 */
`ifndef EXT_BUS_REGS_VH
`define EXT_BUS_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_WINDOW0      16'hFF0C
`define OFS_WINDOW1      16'hFF14
`define OFS_WINDOW2      16'hFF16
`define OFS_WINDOW3      16'hFF18
`define OFS_WINDOW4      16'hFF1A
`define OFS_PIN_CONFIG   16'hF108
`define OFS_STATUS       16'hFF1C

// ----------------------------------------------------------------------
// bus_window_config fields
// ----------------------------------------------------------------------
`define F_WAIT_LO        0
`define F_WAIT_HI        3
`define F_CMD_DELAY      4
`define F_TRI_WAIT       5
`define F_TYPE_LO        6
`define F_TYPE_HI        7
`define F_ALE_LONG       9
`define F_BUS_ON         10
`define F_RDY_ON         12
`define F_RDY_POL        13
`define F_CS_READ        14
`define F_CS_WRITE       15
`define WINDOW_WMASK     16'hF6FF
`define WINDOW_RESET     16'h0000
`define WAIT_MAX         4'hF

// ----------------------------------------------------------------------
// reset_pin_config fields
// ----------------------------------------------------------------------
`define F_WR_MODE        0
`define F_CS_CNT_LO      1
`define F_CS_CNT_HI      2
`define F_SEG_CNT_LO     3
`define F_SEG_CNT_HI     4
`define F_CLK_LO         5
`define F_CLK_HI         7
`define PIN_CONFIG_RESET 8'hFF

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define F_ST_BUSY        0
`define F_ST_EMPTY       1
`define F_ST_DROPPED     2

`endif

// ### src/external_bus_config.v
/*
 * External bus controller configuration: five window configuration
 * registers, the strap-loaded reset configuration register, a request
 * FIFO and a bus cycle engine that applies the configured timing.
 * Assumes ref_clk is the CPU clock; one clock is one clock phase unit.
 */
// Summary of operation
// - wait states inserted equal fifteen minus the cycle wait count.
// - command delay select 0 delays the command one phase after the latch strobe falls.
// - tristate wait select 0 adds one wait state for memory tristate time.
// - bus type 00/01/10/11 gives 8-bit demux, 8-bit mux, 16-bit demux, 16-bit mux.
// - window 0 bus type is loaded from the configuration port pins during reset.
// - latch strobe lengthen 1 gives a lengthened address latch strobe.
// - window bus on 0 disables external access for that window.
// - ready handshake on 1 ends cycles by the ready input, else by the wait count.
// - ready polarity 0 means ready low is active, 1 means ready high is active.
// - select on read only 1 asserts chip select only during the read command.
// - select on write only 1 asserts chip select only during the write command.
// - write strobe mode 0 turns write into low-byte and byte-high into high-byte strobe.
// - select line count 00/01/10/11 enables 3, 2, 0 or 5 chip selects.
// - segment line count 00/01/10/11 enables 4, 0, 8 or 2 segment lines.
// - cpu clock ratio 000..111 gives 2.5,0.5,10,1,5,2,3,4 times the oscillator.
// - reset configuration bits 4:0 are loaded from the port pins during every reset.
// - clock ratio bits load only on long reset; undriven pins read all ones.
`include "ext_bus_regs.vh"
`default_nettype none

// ----------------------------------------------------------------------
// request fifo
// ----------------------------------------------------------------------
module ext_bus_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             ref_clk,
    input  wire             reset,
    input  wire             ce,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    // full and empty come straight from the occupancy count
    assign inReady  = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // pointers wrap at DEPTH, which need not be a power of two
    always @(posedge ref_clk) begin
        if (reset) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                mem[wrPtr] <= inData;
                wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                          : wrPtr + 1'b1;
            end
            if (pop)
                rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                          : rdPtr + 1'b1;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end
endmodule

// ----------------------------------------------------------------------
// top: registers and bus cycle engine
// ----------------------------------------------------------------------
module external_bus_config #(
    parameter FIFO_DEPTH = 16,
    parameter WINDOWS    = 5
) (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        ce,
    input  wire        longReset,
    input  wire        extAccessPin,
    input  wire [15:0] configPortPins,
    input  wire [15:0] regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [15:0] regRdData,
    input  wire        reqValid,
    output wire        reqReady,
    input  wire        reqWrite,
    input  wire [2:0]  reqWindow,
    input  wire [1:0]  reqByteEn,
    input  wire [23:0] reqAddr,
    input  wire [15:0] reqData,
    output reg         rspValid,
    output reg  [15:0] rspData,
    output reg         addrLatch,
    output reg         readCmd_n,
    output reg         writeCmd_n,
    output reg         byteHighEnable_n,
    output reg  [4:0]  chipSelect_n,
    output reg  [7:0]  segmentAddr,
    output reg  [15:0] lowAddr,
    input  wire [15:0] dataIn,
    output reg  [15:0] dataOut,
    output reg         dataOutEn_n,
    input  wire        readyPin,
    output wire [4:0]  csEnableMask,
    output wire [7:0]  segEnableMask,
    output reg  [4:0]  cpuRatioTimes2
);
    localparam RQW = 1 + 3 + 2 + 24 + 16;
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ALE  = 6'h02;
    localparam [5:0] ST_DLY  = 6'h04;
    localparam [5:0] ST_CMD  = 6'h08;
    localparam [5:0] ST_TRI  = 6'h10;
    localparam [5:0] ST_END  = 6'h20;

    reg  [15:0]    windowCfg [0:WINDOWS-1];
    reg  [7:0]     pinConfig;
    reg            dropped;
    reg  [15:0]    pinSync1, pinSync2, pinSync3;
    reg            eaSync1, eaSync2, eaSync3;
    reg            rdySync1, rdySync2, rdySync3;
    reg            readyLevel;
    reg  [5:0]     state;
    reg  [5:0]     next_state;
    reg  [3:0]     waitCnt;
    reg            aleLong;
    reg  [RQW-1:0] cur;
    reg  [15:0]    curCfg;
    wire [RQW-1:0] act;
    wire [15:0]    actCfg;
    wire [RQW-1:0] fifoOut;
    wire           fifoValid;
    wire           fifoPop;
    wire           cmdPhase;
    wire           selAct;
    wire           curWrite;
    wire [2:0]     curWin;
    wire [1:0]     curBe;
    wire [15:0]    headCfg;
    wire [1:0]     busType;
    wire           readyActive;
    wire           cycleDone;
    integer        i;

    ext_bus_fifo #(.WIDTH(RQW), .DEPTH(FIFO_DEPTH), .AW(4)) reqFifo (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .ce       (ce),
        .inValid  (reqValid),
        .inReady  (reqReady),
        .inData   ({reqWrite, reqWindow, reqByteEn, reqAddr, reqData}),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoOut)
    );

    // fields of the request in flight, or of the head while idle
    assign act      = (state == ST_IDLE && fifoValid) ? fifoOut : cur;
    assign actCfg   = (state == ST_IDLE && fifoValid) ? headCfg : curCfg;
    assign curWrite = act[RQW-1];
    assign curWin   = act[RQW-2:RQW-4];
    assign curBe    = act[RQW-5:RQW-6];
    assign busType  = actCfg[`F_TYPE_HI:`F_TYPE_LO];
    assign headCfg  = (fifoOut[RQW-2:RQW-4] < WINDOWS)
                    ? windowCfg[fifoOut[RQW-2:RQW-4]] : 16'h0000;
    assign fifoPop  = (state == ST_IDLE);
    assign cmdPhase = (state == ST_CMD);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // three stages; a config port or ready pin change counts only once stages two and three agree; external access is taken from stage three
    always @(posedge ref_clk) begin
        if (ce) begin
            pinSync1 <= configPortPins;
            pinSync2 <= pinSync1;
            pinSync3 <= pinSync2;
            eaSync1  <= extAccessPin;
            eaSync2  <= eaSync1;
            eaSync3  <= eaSync2;
            rdySync1 <= readyPin;
            rdySync2 <= rdySync1;
            rdySync3 <= rdySync2;
        end
    end

    // filtered ready level, polarity applied later
    always @(posedge ref_clk) begin
        if (reset)
            readyLevel <= 1'b1;
        else if (ce && rdySync2 == rdySync3)
            readyLevel <= rdySync3;
    end

    assign readyActive = (readyLevel == curCfg[`F_RDY_POL]);
    assign cycleDone   = curCfg[`F_RDY_ON] ? readyActive
                                           : (waitCnt == 4'h0);

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // straps are re-captured on every reset cycle, so the value present
    // at release is the one kept; unstable pins keep the old capture
    always @(posedge ref_clk) begin
        if (reset) begin
            if (ce) begin
                if (pinSync2[15:8] == pinSync3[15:8]) begin
                    pinConfig[4:0] <= pinSync3[12:8];
                    if (longReset)
                        pinConfig[7:5] <= pinSync3[15:13];
                end
                for (i = 0; i < WINDOWS; i = i + 1)
                    windowCfg[i] <= `WINDOW_RESET;
                if (pinSync2[7:6] == pinSync3[7:6])
                    windowCfg[0][`F_TYPE_HI:`F_TYPE_LO] <= pinSync3[7:6];
                // external start: window 0 comes up active, long strobe
                windowCfg[0][`F_BUS_ON]   <= ~eaSync3;
                windowCfg[0][`F_ALE_LONG] <= ~eaSync3;
            end
            dropped <= 1'b0;
        end else if (ce) begin
            for (i = 0; i < WINDOWS; i = i + 1)
                if (regWrite && (
                    (i == 0 && regAddr == `OFS_WINDOW0) ||
                    (i == 1 && regAddr == `OFS_WINDOW1) ||
                    (i == 2 && regAddr == `OFS_WINDOW2) ||
                    (i == 3 && regAddr == `OFS_WINDOW3) ||
                    (i == 4 && regAddr == `OFS_WINDOW4)))
                    windowCfg[i] <= regWrData & `WINDOW_WMASK;
            // sticky flag: a new drop wins over a clear in the same cycle
            if (state == ST_IDLE && fifoValid && !headCfg[`F_BUS_ON])
                dropped <= 1'b1;
            else if (regWrite && regAddr == `OFS_STATUS
                     && regWrData[`F_ST_DROPPED])
                dropped <= 1'b0;
        end
    end

    // read port, data valid in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (reset)
            regRdData <= 16'h0000;
        else if (ce) begin
            regRdData <= 16'h0000;
            if (regRead)
                case (regAddr)
                    `OFS_WINDOW0:    regRdData <= windowCfg[0];
                    `OFS_WINDOW1:    regRdData <= windowCfg[1];
                    `OFS_WINDOW2:    regRdData <= windowCfg[2];
                    `OFS_WINDOW3:    regRdData <= windowCfg[3];
                    `OFS_WINDOW4:    regRdData <= windowCfg[4];
                    `OFS_PIN_CONFIG: regRdData <= {8'h00, pinConfig};
                    `OFS_STATUS:     regRdData <= {13'h0000, dropped,
                                          ~fifoValid, state != ST_IDLE};
                    default:         regRdData <= 16'h0000;
                endcase
        end
    end

    // ------------------------------------------------------------------
    // strap decodes
    // ------------------------------------------------------------------
    assign csEnableMask =
        (pinConfig[`F_CS_CNT_HI:`F_CS_CNT_LO] == 2'b00) ? 5'h07 :
        (pinConfig[`F_CS_CNT_HI:`F_CS_CNT_LO] == 2'b01) ? 5'h03 :
        (pinConfig[`F_CS_CNT_HI:`F_CS_CNT_LO] == 2'b10) ? 5'h00 : 5'h1F;
    assign segEnableMask =
        (pinConfig[`F_SEG_CNT_HI:`F_SEG_CNT_LO] == 2'b00) ? 8'h0F :
        (pinConfig[`F_SEG_CNT_HI:`F_SEG_CNT_LO] == 2'b01) ? 8'h00 :
        (pinConfig[`F_SEG_CNT_HI:`F_SEG_CNT_LO] == 2'b10) ? 8'hFF : 8'h03;

    // ratio given in halves so that 2.5 and 0.5 stay whole numbers
    always @* begin
        case (pinConfig[`F_CLK_HI:`F_CLK_LO])
            3'b000:  cpuRatioTimes2 = 5'h05;
            3'b001:  cpuRatioTimes2 = 5'h01;
            3'b010:  cpuRatioTimes2 = 5'h14;
            3'b011:  cpuRatioTimes2 = 5'h02;
            3'b100:  cpuRatioTimes2 = 5'h0A;
            3'b101:  cpuRatioTimes2 = 5'h04;
            3'b110:  cpuRatioTimes2 = 5'h06;
            default: cpuRatioTimes2 = 5'h08;
        endcase
    end

    // ------------------------------------------------------------------
    // bus cycle engine
    // ------------------------------------------------------------------
    always @* begin
        case (state)
            ST_IDLE: next_state = (fifoValid && headCfg[`F_BUS_ON])
                                  ? ST_ALE : ST_IDLE;
            ST_ALE:  next_state = aleLong ? ST_ALE
                                : (curCfg[`F_CMD_DELAY] ? ST_CMD : ST_DLY);
            ST_DLY:  next_state = ST_CMD;
            ST_CMD:  next_state = !cycleDone ? ST_CMD
                                : (curCfg[`F_TRI_WAIT] ? ST_END : ST_TRI);
            ST_TRI:  next_state = ST_END;
            ST_END:  next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // one clock is one phase unit; disabled windows drop the request
    always @(posedge ref_clk) begin
        if (reset) begin
            state    <= ST_IDLE;
            cur      <= {RQW{1'b0}};
            curCfg   <= 16'h0000;
            waitCnt  <= 4'h0;
            aleLong  <= 1'b0;
            rspValid <= 1'b0;
            rspData  <= 16'h0000;
        end else if (ce) begin
            state    <= next_state;
            rspValid <= 1'b0;
            if (state == ST_IDLE && fifoValid) begin
                cur     <= fifoOut;
                curCfg  <= headCfg;
                aleLong <= headCfg[`F_ALE_LONG];
                waitCnt <= `WAIT_MAX - headCfg[`F_WAIT_HI:`F_WAIT_LO];
            end
            if (state == ST_ALE)
                aleLong <= 1'b0;
            if (cmdPhase && !cycleDone && waitCnt != 4'h0)
                waitCnt <= waitCnt - 1'b1;
            if (cmdPhase && cycleDone && !curWrite) begin
                rspValid <= 1'b1;
                rspData  <= busType[1] ? dataIn : {8'h00, dataIn[7:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------------
    // selects follow the next state like the strobes
    assign selAct = (next_state != ST_IDLE) && (next_state != ST_END) &&
        (curWrite ? (!actCfg[`F_CS_WRITE] || next_state == ST_CMD)
                  : (!actCfg[`F_CS_READ]  || next_state == ST_CMD));

    always @(posedge ref_clk) begin
        if (reset) begin
            addrLatch        <= 1'b0;
            readCmd_n        <= 1'b1;
            writeCmd_n       <= 1'b1;
            byteHighEnable_n <= 1'b1;
            chipSelect_n     <= 5'h1F;
            segmentAddr      <= 8'h00;
            lowAddr          <= 16'h0000;
            dataOut          <= 16'h0000;
            dataOutEn_n      <= 1'b1;
        end else if (ce) begin
            addrLatch   <= (next_state == ST_ALE);
            readCmd_n   <= ~(next_state == ST_CMD && !curWrite);
            segmentAddr <= act[39:32] & segEnableMask;
            lowAddr     <= busType[0] ? 16'h0000 : act[31:16];
            // multiplexed types put the address on data while latching
            if (next_state == ST_ALE && busType[0]) begin
                dataOut     <= act[31:16];
                dataOutEn_n <= 1'b0;
            end else if (curWrite && (next_state == ST_DLY
                                      || next_state == ST_CMD)) begin
                dataOut     <= act[15:0];
                dataOutEn_n <= 1'b0;
            end else
                dataOutEn_n <= 1'b1;
            if (!pinConfig[`F_WR_MODE]) begin
                writeCmd_n       <= ~(next_state == ST_CMD && curWrite
                                      && curBe[0]);
                byteHighEnable_n <= ~(next_state == ST_CMD && curWrite
                                      && curBe[1]);
            end else begin
                writeCmd_n       <= ~(next_state == ST_CMD && curWrite);
                byteHighEnable_n <= ~(next_state != ST_IDLE
                                      && next_state != ST_END
                                      && curBe[1] && busType[1]);
            end
            for (i = 0; i < 5; i = i + 1)
                chipSelect_n[i] <= ~(csEnableMask[i] && curWin == i && selAct);
        end
    end

endmodule
`default_nettype wire

// ### testbench/external_bus_config_asserts.sv
/* pin-level checker for external_bus_config
   assumes it is bound to every instance of that module */
`default_nettype none
module external_bus_config_asserts (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        regRead,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regRdData,
    input wire logic        rspValid,
    input wire logic        addrLatch,
    input wire logic        readCmd_n,
    input wire logic        writeCmd_n,
    input wire logic        dataOutEn_n,
    input wire logic [4:0]  chipSelect_n,
    input wire logic [7:0]  segmentAddr,
    input wire logic [4:0]  csEnableMask,
    input wire logic [7:0]  segEnableMask,
    input wire logic [4:0]  cpuRatioTimes2
);
timeunit 1ns;
timeprecision 1ps;
// --------------------------
// port relations
// --------------------------
// one clock, quiet in reset
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
a_rd_idle: assert property (!regRead |=> regRdData == 16'h0000)
    else $error("read data not idle");
a_pin_upper: assert property (regRead && regAddr == 16'hF108
    |=> regRdData[15:8] == 8'h00) else $error("strap word upper set");
a_cs_lines: assert property (csEnableMask inside
    {5'h07, 5'h03, 5'h00, 5'h1F}) else $error("bad select mask");
a_cs_gated: assert property ((~chipSelect_n & ~csEnableMask)
    == 5'h00) else $error("disabled select driven");
a_seg_lines: assert property (segEnableMask inside
    {8'h0F, 8'h00, 8'hFF, 8'h03}) else $error("bad segment mask");
a_seg_gated: assert property ((segmentAddr & ~segEnableMask)
    == 8'h00) else $error("disabled segment line set");
a_clk_ratio: assert property (cpuRatioTimes2 inside
    {5'd5, 5'd1, 5'd20, 5'd2, 5'd10, 5'd4, 5'd6, 5'd8})
    else $error("bad clock ratio");
a_cmd_latch: assert property ($fell(readCmd_n)
    |-> $past(addrLatch) || $past(addrLatch, 2))
    else $error("command not after latch strobe");
a_rsp_pulse: assert property (rspValid |=> !rspValid)
    else $error("response longer than one cycle");
a_wr_drive: assert property (!writeCmd_n |-> !dataOutEn_n)
    else $error("write without data drive");
endmodule

bind external_bus_config external_bus_config_asserts u_chk (
    .ref_clk(ref_clk), .reset(reset), .regRead(regRead),
    .regAddr(regAddr), .regRdData(regRdData), .rspValid(rspValid),
    .addrLatch(addrLatch), .readCmd_n(readCmd_n),
    .writeCmd_n(writeCmd_n), .dataOutEn_n(dataOutEn_n),
    .chipSelect_n(chipSelect_n), .segmentAddr(segmentAddr),
    .csEnableMask(csEnableMask), .segEnableMask(segEnableMask),
    .cpuRatioTimes2(cpuRatioTimes2)
);
`default_nettype wire

// ### testbench/ext_bus_partner.sv
/* memory on the external bus: answers reads, gives ready late
   assumes it shares ref_clk with the block */
`default_nettype none
module ext_bus_partner (
    input  wire logic        ref_clk,
    input  wire logic        readCmd_n,
    input  wire logic        writeCmd_n,
    input  wire logic        readyPol,
    input  wire logic [7:0]  dly,
    input  wire logic [15:0] lowAddr,
    output logic      [15:0] dataIn,
    output logic             readyPin
);
timeunit 1ns;
timeprecision 1ps;
logic [7:0]  cnt = 8'h00;
logic [15:0] last = 16'h0000;
// count command cycles; released bus toggles so stale data never passes
always @(posedge ref_clk) begin
    cnt <= (readCmd_n && writeCmd_n) ? 8'h00 : cnt + 8'h01;
    last <= dataIn;
end
// active level only after dly command cycles
assign readyPin = (cnt >= dly) ? readyPol : ~readyPol;
assign dataIn = !readCmd_n ? ~lowAddr : ~last;
endmodule
`default_nettype wire

// ### testbench/test_external_bus_config.sv
/* bench for external_bus_config: straps, registers, bus cycles
   assumes the memory model stands on the bus pins */
`default_nettype none
module test_external_bus_config;
timeunit 1ns;
timeprecision 1ps;
logic        ref_clk = 1'b0, reset = 1'b1, ce = 1'b1, full;
logic        longReset = 1'b1, extAccessPin = 1'b1, readyPol = 1'b1;
logic        regWrite = 1'b0, regRead = 1'b0, reqValid = 1'b0;
logic        reqWrite = 1'b0, reqReady, rspValid, addrLatch, readyPin;
logic        readCmd_n, writeCmd_n, byteHighEnable_n, dataOutEn_n;
logic [15:0] configPortPins = 16'h0000, regAddr = 16'h0000, wrSeen;
logic [15:0] regWrData = 16'h0000, reqData = 16'h0000, regRdData;
logic [15:0] rspData, lowAddr, dataIn, dataOut;
logic [23:0] reqAddr = 24'h000000;
logic [2:0]  reqWindow = 3'h0;
logic [1:0]  reqByteEn = 2'h3;
logic [7:0]  dly = 8'h06, p, segmentAddr, segEnableMask;
logic [4:0]  chipSelect_n, csEnableMask, cpuRatioTimes2;
int          error_cnt, n_compared, k, i, lowCnt, csOut, rspCnt;
logic [15:0] ratio [8] = '{16'h5, 16'h1, 16'h14, 16'h2,
                           16'hA, 16'h4, 16'h6, 16'h8};
logic [15:0] csT [4] = '{16'h07, 16'h03, 16'h00, 16'h1F};
logic [15:0] segT [4] = '{16'h0F, 16'h00, 16'hFF, 16'h03};

external_bus_config u_dut (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .longReset(longReset),
    .extAccessPin(extAccessPin), .configPortPins(configPortPins),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqWindow(reqWindow),
    .reqByteEn(reqByteEn), .reqAddr(reqAddr), .reqData(reqData),
    .rspValid(rspValid), .rspData(rspData), .addrLatch(addrLatch),
    .readCmd_n(readCmd_n), .writeCmd_n(writeCmd_n),
    .byteHighEnable_n(byteHighEnable_n), .chipSelect_n(chipSelect_n),
    .segmentAddr(segmentAddr), .lowAddr(lowAddr), .dataIn(dataIn),
    .dataOut(dataOut), .dataOutEn_n(dataOutEn_n), .readyPin(readyPin),
    .csEnableMask(csEnableMask), .segEnableMask(segEnableMask),
    .cpuRatioTimes2(cpuRatioTimes2)
);
ext_bus_partner u_mem (
    .ref_clk(ref_clk), .readCmd_n(readCmd_n), .writeCmd_n(writeCmd_n),
    .readyPol(readyPol), .dly(dly), .lowAddr(lowAddr),
    .dataIn(dataIn), .readyPin(readyPin)
);
// --------------------------
// clock, monitors, tasks
// --------------------------
// 40 MHz
initial forever #12.5 ref_clk = ~ref_clk;
// command length, stray selects and responses seen on the pins
always @(posedge ref_clk) begin
    if (readCmd_n === 1'b0) lowCnt <= lowCnt + 1;
    if (readCmd_n === 1'b1 && chipSelect_n !== 5'h1F) csOut <= csOut + 1;
    if (rspValid === 1'b1) rspCnt <= rspCnt + 1;
    if (writeCmd_n === 1'b0) wrSeen <= dataOut;
end
task automatic cmp(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
        error_cnt++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic wr(input logic [15:0] a, v);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWrite <= 1'b0;
endtask
task automatic chk(input logic [15:0] a, exp);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 cmp(regRdData, exp);
endtask
// five reset edges let straps clear the synchroniser
task automatic rst(input logic [15:0] pins, input logic lng, ea);
    @(posedge ref_clk);
    reset <= 1'b1;
    configPortPins <= pins;
    longReset <= lng;
    extAccessPin <= ea;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
endtask
task automatic req(input logic [2:0] w, input logic wrt, input logic [23:0] a);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqWindow <= w;
    reqWrite <= wrt;
    reqAddr <= a;
    reqData <= 16'hA55A;
    k = 0;
    do begin @(posedge ref_clk); k++; end while (reqReady !== 1'b1 && k < 300);
    reqValid <= 1'b0;
endtask
task automatic waitRsp(input logic [15:0] exp);
    for (k = 0; rspValid !== 1'b1 && k < 300; k++) @(posedge ref_clk);
    cmp({15'h0, rspValid}, 16'h1);
    cmp(rspData, exp);
endtask
task automatic conclude;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
// hang guard, far past a clean run
initial begin
    #300us;
    error_cnt++;
    conclude();
end
// --------------------------
// tests
// --------------------------
initial begin
    // every clock code on a long reset, line counts cycling
    for (i = 0; i < 8; i++) begin
        p = {i[2:0], i[1:0], i[1:0], i[0]};
        rst({p, 8'h00}, 1'b1, 1'b1);
        chk(16'hF108, {8'h00, p});
        cmp({11'h0, cpuRatioTimes2}, ratio[i]);
        cmp({11'h0, csEnableMask}, csT[i[1:0]]);
        cmp({8'h0, segEnableMask}, segT[i[1:0]]);
    end
    // short reset keeps the clock code; external start enables window 0
    rst(16'h00C0, 1'b0, 1'b0);
    chk(16'hF108, 16'h00E0);
    chk(16'hFF0C, 16'h06C0);
    wr(16'hF108, 16'h0000);
    chk(16'hF108, 16'h00E0);
    for (i = 0; i < 4; i++) begin
        wr(16'hFF14 + 16'(2 * i), 16'hFFFF);
        chk(16'hFF14 + 16'(2 * i), 16'hF6FF);
    end
    chk(16'hFF00, 16'h0000);
    wr(16'hFF1A, 16'h0000);
    // wait count sets command length; select only while reading
    for (i = 0; i < 2; i++) begin
        wr(16'hFF14, i ? 16'h44BC : 16'h44BF);
        lowCnt = 0;
        csOut = 0;
        req(3'h1, 1'b0, 24'h123456);
        waitRsp(16'hCBA9);
        cmp(16'(lowCnt), i ? 16'h4 : 16'h1);
        cmp(16'(csOut), 16'h0);
    end
    req(3'h1, 1'b1, 24'h000022);
    // ready ends the cycle at either polarity, not the wait count
    for (i = 0; i < 2; i++) begin
        readyPol <= i[0];
        wr(16'hFF16, i ? 16'h34BF : 16'h14BF);
        lowCnt = 0;
        req(3'h2, 1'b0, 24'h000100);
        waitRsp(16'hFEFF);
        cmp(16'(lowCnt > 6), 16'h1);
    end
    cmp(wrSeen, 16'hA55A);
    // disabled window is dropped and flagged
    req(3'h4, 1'b0, 24'h000040);
    repeat (20) @(posedge ref_clk);
    chk(16'hFF1C, 16'h0006);
    wr(16'hFF1C, 16'h0004);
    chk(16'hFF1C, 16'h0002);
    // slow memory stalls the queue until it refuses, then drains
    dly = 8'd30;
    full = 1'b0;
    rspCnt = 0;
    for (i = 0; i < 20; i++) begin
        req(3'h2, 1'b0, 24'h000010);
        if (k > 1) full = 1'b1;
    end
    cmp({15'h0, full}, 16'h1);
    for (k = 0; rspCnt < 20 && k < 2000; k++) @(posedge ref_clk);
    cmp(16'(rspCnt), 16'd20);
    chk(16'hFF1C, 16'h0002);
    conclude();
end
endmodule
`default_nettype wire
